// [sucsp_pkg.sv]
/*
 * Shared constants for the serial unit clock, stop and priority bank:
 * register offsets, field positions, reset values and the prescaler tick
 * function.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
`default_nettype none
package sucsp_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CODE_W = 4;
    localparam int unsigned DIV_W = 15;

    // Register byte offsets
    localparam logic [7:0] OFS_PER_CLK_EN = 8'h00;
    localparam logic [7:0] OFS_PRESCALE = 8'h04;
    localparam logic [7:0] OFS_STOP_TRIG = 8'h08;
    localparam logic [7:0] OFS_PRIO_LOW = 8'h0c;
    localparam logic [7:0] OFS_PRIO_HIGH = 8'h10;
    localparam logic [7:0] OFS_START_TRIG = 8'h14;
    localparam logic [7:0] OFS_CH_STATUS = 8'h18;
    localparam logic [7:0] OFS_CH_CLK_SEL = 8'h1c;

    // Field positions
    localparam int unsigned UNIT0_EN_BIT = 2;
    localparam int unsigned FIRST_CODE_LSB = 0;
    localparam int unsigned SECOND_CODE_LSB = 4;
    localparam int unsigned PRIO_CH0_BIT = 5;

    // Reset values and fixed bits
    localparam logic [7:0] PER_CLK_EN_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'hff;
    localparam logic [7:0] PRIO_FIXED_ONES = 8'h18;

    // Tick for a power-of-two divide: once every 2^code enabled cycles
    function automatic logic div_tick(input logic [DIV_W-1:0] cnt,
                                      input logic [CODE_W-1:0] code);
        logic [DIV_W:0] mask;
        mask = (16'h0001 << code) - 16'h0001;
        div_tick = ((cnt & mask[DIV_W-1:0]) == mask[DIV_W-1:0]);
    endfunction : div_tick
endpackage : sucsp_pkg
`default_nettype wire

// [sucsp_prescaler.sv]
/*
 * Two power-of-two operation clock tick generators sharing one counter.
 * Assumes i_enable already folds in the clock enable and the unit gate.
 */
`timescale 1ns/10ps
`default_nettype none
module sucsp_prescaler (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [sucsp_pkg::CODE_W-1:0] i_first_code,
    input wire logic [sucsp_pkg::CODE_W-1:0] i_second_code,
    output logic o_first_tick,
    output logic o_second_tick
);
    typedef struct packed {
        logic [sucsp_pkg::DIV_W-1:0] cnt;
        logic first_tick;
        logic second_tick;
    } sucsp_div_s;

    sucsp_div_s s;
    sucsp_div_s next_s;

    always_comb begin
        // Everything holds while disabled, so a clock-enable gap loses no
        // tick; code 0 ticks every enabled cycle
        next_s = s;
        if (i_enable) begin
            next_s.cnt = s.cnt + 15'h0001;
            next_s.first_tick =
                sucsp_pkg::div_tick(s.cnt, i_first_code);
            next_s.second_tick =
                sucsp_pkg::div_tick(s.cnt, i_second_code);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_first_tick = s.first_tick;
    assign o_second_tick = s.second_tick;
endmodule : sucsp_prescaler
`default_nettype wire

// [sucsp_bank.sv]
/*
 * APB register bank that gates the serial unit input clock, selects two
 * prescaled operation clocks, starts and stops channels, and forms the
 * channel 0 transfer-end interrupt priority level.
 * Assumes a 200 MHz i_clock, a synchronous active-high reset and an APB
 * master on the same clock.
 */
// Behaviour
// - unit clock runs only while enable bit set
// - first clock divides by two to code
// - stop write of one clears channel enable
// - priority level from one bit per register
// - channel clock select picks first or second
`timescale 1ns/10ps
`default_nettype none
module sucsp_bank #(
    parameter int unsigned CHANNELS = 4
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [sucsp_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [sucsp_pkg::DATA_W-1:0] i_pwdata,
    output logic o_pready,
    output logic [sucsp_pkg::DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    output logic o_unit0_clock_en,
    output logic [CHANNELS-1:0] o_channel_enabled,
    output logic [CHANNELS-1:0] o_channel_tick,
    output logic [CHANNELS-1:0] o_channel_stop,
    output logic [1:0] o_xfer_end_priority
);
    // Status and select registers hold one bit per channel in a 16-bit field
    if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
        $error("CHANNELS must be 1 to 16");
    end

    typedef struct packed {
        logic [7:0] per_en;
        logic [7:0] prescale;
        logic [7:0] prio_low;
        logic [7:0] prio_high;
        logic [CHANNELS-1:0] ch_en;
        logic [CHANNELS-1:0] ch_sel;
        logic [CHANNELS-1:0] ch_tick;
        logic [CHANNELS-1:0] ch_stop;
        logic [1:0] prio;
        logic pready;
        logic pslverr;
        logic [sucsp_pkg::DATA_W-1:0] prdata;
    } sucsp_state_s;

    sucsp_state_s s;
    sucsp_state_s next_s;
    logic first_tick;
    logic second_tick;
    logic div_enable;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: frozen while the unit clock is gated off
    assign div_enable = i_clk_en & s.per_en[sucsp_pkg::UNIT0_EN_BIT];

    sucsp_prescaler u_prescaler (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(div_enable),
        .i_first_code(s.prescale[sucsp_pkg::FIRST_CODE_LSB +: 4]),
        .i_second_code(s.prescale[sucsp_pkg::SECOND_CODE_LSB +: 4]),
        .o_first_tick(first_tick),
        .o_second_tick(second_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == sucsp_pkg::OFS_PER_CLK_EN)
            || (a == sucsp_pkg::OFS_PRESCALE)
            || (a == sucsp_pkg::OFS_STOP_TRIG)
            || (a == sucsp_pkg::OFS_PRIO_LOW)
            || (a == sucsp_pkg::OFS_PRIO_HIGH)
            || (a == sucsp_pkg::OFS_START_TRIG)
            || (a == sucsp_pkg::OFS_CH_STATUS)
            || (a == sucsp_pkg::OFS_CH_CLK_SEL);
    endfunction : is_mapped

    function automatic logic [31:0] read_word(input sucsp_state_s st,
                                               input logic [7:0] a);
        read_word = 32'h0000_0000;
        unique case (a)
            sucsp_pkg::OFS_PER_CLK_EN: read_word[7:0] = st.per_en;
            sucsp_pkg::OFS_PRESCALE: read_word[7:0] = st.prescale;
            sucsp_pkg::OFS_PRIO_LOW:
                read_word[7:0] = st.prio_low | sucsp_pkg::PRIO_FIXED_ONES;
            sucsp_pkg::OFS_PRIO_HIGH:
                read_word[7:0] = st.prio_high | sucsp_pkg::PRIO_FIXED_ONES;
            sucsp_pkg::OFS_CH_STATUS: read_word[CHANNELS-1:0] = st.ch_en;
            sucsp_pkg::OFS_CH_CLK_SEL: read_word[CHANNELS-1:0] = st.ch_sel;
            // Trigger registers and holes read as zero
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic wr;
        logic [CHANNELS-1:0] start;
        logic [CHANNELS-1:0] stop;
        logic [CHANNELS-1:0] pick;
        logic unit_on;
        wr = 1'b0;
        start = '0;
        stop = '0;
        pick = '0;
        unit_on = 1'b0;
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        // Setup phase decodes, so the access phase needs no wait state
        if (i_psel && !i_penable) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !is_mapped(i_paddr);
            next_s.prdata = i_pwrite ? 32'h0000_0000 : read_word(s, i_paddr);
        end
        wr = i_psel && i_penable && s.pready && i_pwrite && !s.pslverr;
        if (wr) begin
            unique case (i_paddr)
                sucsp_pkg::OFS_PER_CLK_EN: next_s.per_en = i_pwdata[7:0];
                sucsp_pkg::OFS_PRESCALE: next_s.prescale = i_pwdata[7:0];
                sucsp_pkg::OFS_PRIO_LOW: next_s.prio_low = i_pwdata[7:0];
                sucsp_pkg::OFS_PRIO_HIGH: next_s.prio_high = i_pwdata[7:0];
                sucsp_pkg::OFS_STOP_TRIG: stop = i_pwdata[CHANNELS-1:0];
                sucsp_pkg::OFS_START_TRIG: start = i_pwdata[CHANNELS-1:0];
                sucsp_pkg::OFS_CH_CLK_SEL:
                    next_s.ch_sel = i_pwdata[CHANNELS-1:0];
                default: next_s.per_en = s.per_en;
            endcase
        end
        // Zero bits do nothing; stop beats a start in the same write
        next_s.ch_en = (s.ch_en | start) & ~stop;
        next_s.ch_stop = stop;
        unit_on = s.per_en[sucsp_pkg::UNIT0_EN_BIT];
        for (int i = 0; i < CHANNELS; i++) begin
            pick[i] = s.ch_sel[i] ? second_tick : first_tick;
        end
        next_s.ch_tick = pick & s.ch_en & {CHANNELS{unit_on}};
        next_s.prio = {s.prio_low[sucsp_pkg::PRIO_CH0_BIT],
                       s.prio_high[sucsp_pkg::PRIO_CH0_BIT]};
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s <= '0;
            s.per_en <= sucsp_pkg::PER_CLK_EN_RESET;
            s.prescale <= sucsp_pkg::PRESCALE_RESET;
            s.prio_low <= sucsp_pkg::PRIO_RESET;
            s.prio_high <= sucsp_pkg::PRIO_RESET;
            s.prio <= {sucsp_pkg::PRIO_RESET[sucsp_pkg::PRIO_CH0_BIT],
                       sucsp_pkg::PRIO_RESET[sucsp_pkg::PRIO_CH0_BIT]};
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_pready = s.pready;
    assign o_prdata = s.prdata;
    assign o_pslverr = s.pslverr;
    assign o_unit0_clock_en = s.per_en[sucsp_pkg::UNIT0_EN_BIT];
    assign o_channel_enabled = s.ch_en;
    assign o_channel_tick = s.ch_tick;
    assign o_channel_stop = s.ch_stop;
    assign o_xfer_end_priority = s.prio;
endmodule : sucsp_bank
`default_nettype wire

// [sucsp_bank_props.sv]
/* Assertions for the serial clock, stop and priority bank.
   Sees only the bank's ports; bound to every sucsp_bank below. */
`timescale 1ns/10ps
`default_nettype none
module sucsp_bank_props #(
    parameter int unsigned CHANNELS = 4
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic o_unit0_clock_en,
    input wire logic [CHANNELS-1:0] o_channel_enabled,
    input wire logic [CHANNELS-1:0] o_channel_tick,
    input wire logic [CHANNELS-1:0] o_channel_stop,
    input wire logic [1:0] o_xfer_end_priority
);
    logic wr;
    assign wr = i_psel && i_penable && i_pwrite && o_pready && i_clk_en;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////
    property p_unit_en;
        wr && i_paddr == 8'h00 |=> o_unit0_clock_en == $past(i_pwdata[2]);
    endproperty
    a_unit_en: assert property (p_unit_en) else $error("unit enable");
    // One cycle of slack: a tick already launched may still show
    property p_gate;
        !o_unit0_clock_en && !$past(o_unit0_clock_en) |-> o_channel_tick == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("tick while gated");
    property p_stop;
        wr && i_paddr == 8'h08 |=> o_channel_enabled ==
            ($past(o_channel_enabled) & ~$past(i_pwdata[CHANNELS-1:0]));
    endproperty
    a_stop: assert property (p_stop) else $error("stop effect");
    property p_pulse;
        o_channel_stop != '0 |=> o_channel_stop == '0;
    endproperty
    a_pulse: assert property (p_pulse) else $error("stop pulse");
    property p_stop_pulse;
        wr && i_paddr == 8'h08 |=>
            o_channel_stop == $past(i_pwdata[CHANNELS-1:0]);
    endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop bits");
    // Level is registered from the priority registers: two edges of latency
    property p_prio_lo;
        wr && i_paddr == 8'h0c |=> ##1
            o_xfer_end_priority[1] == $past(i_pwdata[5], 2);
    endproperty
    a_prio_lo: assert property (p_prio_lo) else $error("prio msb");
    property p_prio_hi;
        wr && i_paddr == 8'h10 |=> ##1
            o_xfer_end_priority[0] == $past(i_pwdata[5], 2);
    endproperty
    a_prio_hi: assert property (p_prio_hi) else $error("prio lsb");
    c_stop: cover property (wr && i_paddr == 8'h08 && i_pwdata[0]);
    c_err: cover property (o_pready && o_pslverr);
    c_tick: cover property (o_channel_tick != '0);
endmodule : sucsp_bank_props
bind sucsp_bank sucsp_bank_props #(.CHANNELS(CHANNELS)) u_props (
    .i_clock, .i_rst, .i_clk_en, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_unit0_clock_en,
    .o_channel_enabled, .o_channel_tick, .o_channel_stop, .o_xfer_end_priority
);
`default_nettype wire

// [sucsp_bank_tb.sv]
/* Self-checking bench for the serial clock, stop and priority bank.
   The bench is the APB master; clock enable is held high throughout. */
`timescale 1ns/10ps
`default_nettype none
module sucsp_bank_tb;
    logic i_clock, i_rst, psel, penable, pwrite, pready, pslverr, u0en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] en, tick, stop;
    logic [1:0] prio;
    int n_errors, checks, cycles;
    sucsp_bank #(.CHANNELS(4)) u_dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(1'b1), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .o_unit0_clock_en(u0en), .o_channel_enabled(en),
        .o_channel_tick(tick), .o_channel_stop(stop),
        .o_xfer_end_priority(prio));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk
    // Idle cycle first, so release and next setup never share a time step
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd
    // 64 cycles hold a whole number of periods for codes up to 6
    task automatic count(output int n0, output int n1);
        n0 = 0;
        n1 = 0;
        repeat (3) @(posedge i_clock);
        repeat (64) begin
            @(posedge i_clock);
            n0 += int'(tick[0]);
            n1 += int'(tick[1]);
        end
    endtask : count
    task automatic t_reset;
        chk(32'(prio), 32'h3);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'hff);
        rd(8'h10, 32'hff);
        rd(8'h1c, 32'h0);
    endtask : t_reset
    task automatic t_prio;
        logic [1:0] lv;
        for (int l = 0; l < 4; l++) begin
            lv = 2'(l);
            wr(8'h0c, {26'h0, lv[1], 5'h0});
            wr(8'h10, {26'h0, lv[0], 5'h0});
            // Level output trails the register write by two edges
            repeat (2) @(posedge i_clock);
            chk(32'(prio), 32'(lv));
            rd(8'h0c, {26'h0, lv[1], 5'h18});
        end
    endtask : t_prio
    task automatic t_ticks;
        int n0, n1;
        wr(8'h00, 32'h4);
        rd(8'h00, 32'h4);
        chk(32'(u0en), 32'h1);
        wr(8'h08, 32'hf);
        wr(8'h1c, 32'h2);
        wr(8'h14, 32'h3);
        for (int i = 0; i < 2; i++) begin
            wr(8'h04, (i != 0) ? 32'hff50 : 32'h32);
            rd(8'h04, (i != 0) ? 32'h50 : 32'h32);
            count(n0, n1);
            chk(32'(n0), (i != 0) ? 32'd64 : 32'd16);
            chk(32'(n1), (i != 0) ? 32'd2 : 32'd8);
        end
        wr(8'h00, 32'h0);
        count(n0, n1);
        chk(32'(n0 + n1), 32'h0);
    endtask : t_ticks
    task automatic t_stop;
        logic [3:0] seen;
        seen = '0;
        wr(8'h14, 32'hf);
        rd(8'h18, 32'hf);
        wr(8'h08, 32'h5);
        repeat (3) begin
            @(posedge i_clock);
            seen |= stop;
        end
        chk(32'(seen), 32'h5);
        chk(32'(en), 32'ha);
        wr(8'h08, 32'h0);
        rd(8'h18, 32'ha);
        rd(8'h08, 32'h0);
    endtask : t_stop
    task automatic t_unmapped;
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk(32'(e), 32'h1);
        chk(r, 32'h0);
    endtask : t_unmapped
    task automatic complete_run;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        {i_rst, psel, penable, pwrite} = 4'h8;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        t_prio();
        t_ticks();
        t_stop();
        t_unmapped();
        complete_run();
    end
endmodule : sucsp_bank_tb
`default_nettype wire
